// File: src/io_port_pkg.sv
// Shared constants for the general purpose port set.
// Assumes an AXI4-Lite master with 32-bit data and 8-bit byte addresses.
package io_port_pkg;

  // Geometry
  localparam int NUM_PORTS  = 7;
  localparam int PORT_W     = 8;
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 32;
  localparam int SYNC_DEPTH = 2;

  // Port order in the pin vectors and the register map
  localparam int PORT_A = 0;
  localparam int PORT_B = 1;
  localparam int PORT_C = 2;
  localparam int PORT_E = 3;
  localparam int PORT_F = 4;
  localparam int PORT_G = 5;
  localparam int PORT_L = 6;

  // Register map: port p at p * PORT_STRIDE
  localparam logic [7:0] PORT_STRIDE = 8'h10;
  localparam logic [3:0] OFF_CFG     = 4'h0;
  localparam logic [3:0] OFF_DATA    = 4'h4;
  localparam logic [3:0] OFF_PIN     = 4'h8;
  localparam logic [7:0] ADDR_D_DATA = 8'h70;
  localparam logic [7:0] ADDR_OPTION = 8'h74;

  // Reset values
  localparam logic [7:0] CFG_RESET  = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] D_RESET    = 8'hff;

  // Implemented bits per port
  localparam logic [7:0] F_MASK      = 8'h0f;
  localparam logic [7:0] FULL_MASK   = 8'hff;
  localparam logic [7:0] G_DATA_MASK = 8'h3f;

  // Port G bit positions
  localparam int G_IRQ_BIT   = 0;
  localparam int G_WDOG_BIT  = 1;
  localparam int G_T1CAP_BIT = 2;
  localparam int G_T1IO_BIT  = 3;
  localparam int G_SO_BIT    = 4;
  localparam int G_SCK_BIT   = 5;
  localparam int G_SI_BIT    = 6;
  localparam int G_OSC_BIT   = 7;

  // Port G special register bits
  localparam int G_IDLE_BIT  = 6;
  localparam int G_HALT_BIT  = 7;
  localparam int G_PHASE_BIT = 6;
  localparam int G_DELAY_BIT = 7;

  // Port L alternate positions
  localparam int L_UCLK_BIT = 1;
  localparam int L_TXD_BIT  = 2;
  localparam int L_RXD_BIT  = 3;

  // Option register
  localparam int OPT_WDOG_BIT = 0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// File: src/io_pin_sync.sv
// Two-stage synchroniser for a bus of pin levels.
// Assumes each bit is an independent level; no word coherence given.
`timescale 1ns/1ns
module io_pin_sync #(
  parameter int WIDTH = 56
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] pin_level,
  output logic      [WIDTH-1:0] pin_sync
);

  logic [WIDTH-1:0] stage1_reg;

  initial begin
    if (WIDTH < 1) begin
      $error("io_pin_sync: WIDTH must be positive");
    end
  end

  // First stage feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1_reg <= '0;
      pin_sync   <= '0;
    end else begin
      stage1_reg <= pin_level;
      pin_sync   <= stage1_reg;
    end
  end

endmodule

// File: src/io_port_drive.sv
// Registered pin drivers built from configuration and data bits.
// Assumes per-bit overrides come from the port set for dedicated pins.
`timescale 1ns/1ns
module io_port_drive #(
  parameter int WIDTH = 56
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] cfg_bits,
  input  wire logic [WIDTH-1:0] data_bits,
  input  wire logic [WIDTH-1:0] ovr_en,
  input  wire logic [WIDTH-1:0] ovr_out,
  input  wire logic [WIDTH-1:0] ovr_oe,
  input  wire logic [WIDTH-1:0] ovr_pull,
  output logic      [WIDTH-1:0] pin_out,
  output logic      [WIDTH-1:0] pin_oe,
  output logic      [WIDTH-1:0] pin_pullup
);

  initial begin
    if (WIDTH < 1) begin
      $error("io_port_drive: WIDTH must be positive");
    end
  end

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        pin_out[i]    <= 1'b0;
        pin_oe[i]     <= 1'b0;
        pin_pullup[i] <= 1'b0;
      end else if (ovr_en[i]) begin
        pin_out[i]    <= ovr_out[i];
        pin_oe[i]     <= ovr_oe[i];
        pin_pullup[i] <= ovr_pull[i];
      end else begin
        pin_out[i]    <= data_bits[i];
        pin_oe[i]     <= cfg_bits[i];
        pin_pullup[i] <= ~cfg_bits[i] & data_bits[i];
      end
    end
  end

endmodule

// File: src/io_port_set.sv
// Port set: seven bidirectional ports except input-only F4-F7 and G6 and clock output G7, one output-only port, AXI4-Lite registers.
// Assumes pins may be asynchronous to aclk and an AXI4-Lite master on the bus.
`timescale 1ns/1ns
module io_port_set (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [55:0] port_pin_in,
  output logic      [55:0] port_pin_out,
  output logic      [55:0] port_pin_oe,
  output logic      [55:0] port_pin_pullup,
  output logic      [7:0]  port_d_out,
  input  wire logic        oscillator_clock_in,
  input  wire logic        watchdog_output_level,
  output logic             halt_mode_req,
  output logic             idle_mode_req,
  output logic             serial_clock_phase_alt,
  output logic             halt_exit_clock_delay_en,
  output logic             watchdog_enable,
  output logic             external_interrupt_in,
  output logic             timer_one_capture_in,
  output logic             timer_one_io,
  output logic             serial_data_in,
  output logic             sync_serial_clock,
  output logic             serial_receive_pin,
  output logic             serial_clock_pin,
  output logic      [7:0]  wakeup_level
);

  localparam int NP = io_port_pkg::NUM_PORTS;
  localparam int PW = io_port_pkg::PORT_W;
  localparam int VW = NP * PW;
  localparam int GB = io_port_pkg::PORT_G * PW;
  localparam int LB = io_port_pkg::PORT_L * PW;
  localparam int FB = io_port_pkg::PORT_F * PW;

  // Pin vectors are sized for seven byte-wide ports
  initial begin
    if (VW != 56) begin
      $error("io_port_set: pin vector width must be 56");
    end
  end

  logic [PW-1:0]  cfg_reg  [NP];
  logic [PW-1:0]  data_reg [NP];
  logic [PW-1:0]  d_port_reg;
  logic           wdog_en_reg;
  logic [VW-1:0]  cfg_flat;
  logic [VW-1:0]  data_flat;
  logic [VW-1:0]  pin_sync;
  logic [VW-1:0]  ovr_en;
  logic [VW-1:0]  ovr_out;
  logic [VW-1:0]  ovr_oe;
  logic [VW-1:0]  ovr_pull;
  logic           aw_full_reg;
  logic [7:0]     aw_addr_reg;
  logic           w_full_reg;
  logic [31:0]    w_data_reg;
  logic           w_lane0_reg;
  logic           do_write;
  logic           wr_mapped;
  logic [2:0]     wr_port;
  logic [3:0]     wr_off;
  logic           wr_port_ok;
  logic           wr_g_data;

  // Implemented bits per port
  function automatic logic [PW-1:0] cfg_mask(input int p);
    return (p == io_port_pkg::PORT_F) ? io_port_pkg::F_MASK : io_port_pkg::FULL_MASK;
  endfunction

  function automatic logic [PW-1:0] data_mask(input int p);
    if (p == io_port_pkg::PORT_F) begin
      return io_port_pkg::F_MASK;
    end
    if (p == io_port_pkg::PORT_G) begin
      return io_port_pkg::G_DATA_MASK;
    end
    return io_port_pkg::FULL_MASK;
  endfunction

  // Address decode of one byte address
  function automatic logic port_hit(input logic [7:0] a);
    return (a[7:4] < 4'(NP)) && (a[1:0] == 2'b00) &&
           ((a[3:0] == io_port_pkg::OFF_CFG) || (a[3:0] == io_port_pkg::OFF_DATA) ||
            (a[3:0] == io_port_pkg::OFF_PIN));
  endfunction

  // Write channel holding
  assign do_write   = aw_full_reg && w_full_reg && !s_axi_bvalid;
  assign wr_port    = aw_addr_reg[6:4];
  assign wr_off     = aw_addr_reg[3:0];
  assign wr_port_ok = port_hit(aw_addr_reg);
  assign wr_mapped  = wr_port_ok || (aw_addr_reg == io_port_pkg::ADDR_D_DATA) ||
                      (aw_addr_reg == io_port_pkg::ADDR_OPTION);
  assign wr_g_data  = do_write && w_lane0_reg && wr_port_ok &&
                      (wr_port == 3'(io_port_pkg::PORT_G)) &&
                      (wr_off == io_port_pkg::OFF_DATA);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      aw_full_reg   <= 1'b0;
      aw_addr_reg   <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_full_reg   <= 1'b1;
      aw_addr_reg   <= s_axi_awaddr;
    end else if (do_write) begin
      aw_full_reg   <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      w_full_reg   <= 1'b0;
      w_data_reg   <= 32'h0000_0000;
      w_lane0_reg  <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_full_reg   <= 1'b1;
      w_data_reg   <= s_axi_wdata;
      w_lane0_reg  <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_full_reg   <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= io_port_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? io_port_pkg::RESP_OKAY : io_port_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Configuration and data registers per port
  for (genvar p = 0; p < NP; p++) begin : g_port
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cfg_reg[p] <= io_port_pkg::CFG_RESET;
      end else if (do_write && w_lane0_reg && wr_port_ok && wr_port == 3'(p) &&
                   wr_off == io_port_pkg::OFF_CFG) begin
        cfg_reg[p] <= w_data_reg[PW-1:0] & cfg_mask(p);
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        data_reg[p] <= io_port_pkg::DATA_RESET;
      end else if (do_write && w_lane0_reg && wr_port_ok && wr_port == 3'(p) &&
                   wr_off == io_port_pkg::OFF_DATA) begin
        data_reg[p] <= w_data_reg[PW-1:0] & data_mask(p);
      end
    end

    assign cfg_flat[p*PW +: PW]  = cfg_reg[p];
    assign data_flat[p*PW +: PW] = data_reg[p];
  end

  // Output-only port and option register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      d_port_reg <= io_port_pkg::D_RESET;
    end else if (do_write && w_lane0_reg && aw_addr_reg == io_port_pkg::ADDR_D_DATA) begin
      d_port_reg <= w_data_reg[PW-1:0];
    end
  end

  assign port_d_out = d_port_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdog_en_reg <= 1'b0;
    end else if (do_write && w_lane0_reg && aw_addr_reg == io_port_pkg::ADDR_OPTION) begin
      wdog_en_reg <= w_data_reg[io_port_pkg::OPT_WDOG_BIT];
    end
  end

  assign watchdog_enable = wdog_en_reg;

  // Power-save requests, one cycle each
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      halt_mode_req <= 1'b0;
      idle_mode_req <= 1'b0;
    end else begin
      halt_mode_req <= wr_g_data && w_data_reg[io_port_pkg::G_HALT_BIT];
      idle_mode_req <= wr_g_data && w_data_reg[io_port_pkg::G_IDLE_BIT];
    end
  end

  assign serial_clock_phase_alt   = cfg_reg[io_port_pkg::PORT_G][io_port_pkg::G_PHASE_BIT];
  assign halt_exit_clock_delay_en = cfg_reg[io_port_pkg::PORT_G][io_port_pkg::G_DELAY_BIT];
  // The two above are register bits of port G configuration

  // Dedicated pin overrides
  always_comb begin
    ovr_en   = '0;
    ovr_out  = '0;
    ovr_oe   = '0;
    ovr_pull = '0;
    ovr_en[FB+4 +: 4] = 4'hf;
    ovr_en[GB + io_port_pkg::G_SI_BIT] = 1'b1;
    ovr_en[GB + io_port_pkg::G_OSC_BIT]  = 1'b1;
    ovr_oe[GB + io_port_pkg::G_OSC_BIT]  = 1'b1;
    ovr_out[GB + io_port_pkg::G_OSC_BIT] = oscillator_clock_in;
    if (wdog_en_reg) begin
      ovr_en[GB + io_port_pkg::G_WDOG_BIT]   = 1'b1;
      ovr_pull[GB + io_port_pkg::G_WDOG_BIT] = 1'b1;
      ovr_oe[GB + io_port_pkg::G_WDOG_BIT]   = ~watchdog_output_level;
    end
  end

  io_port_drive #(
    .WIDTH (VW)
  ) u_drive (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .cfg_bits   (cfg_flat),
    .data_bits  (data_flat),
    .ovr_en     (ovr_en),
    .ovr_out    (ovr_out),
    .ovr_oe     (ovr_oe),
    .ovr_pull   (ovr_pull),
    .pin_out    (port_pin_out),
    .pin_oe     (port_pin_oe),
    .pin_pullup (port_pin_pullup)
  );

  io_pin_sync #(
    .WIDTH (VW)
  ) u_sync (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pin_level (port_pin_in),
    .pin_sync  (pin_sync)
  );

  // Alternate function taps
  assign external_interrupt_in = pin_sync[GB + io_port_pkg::G_IRQ_BIT];
  assign timer_one_capture_in  = pin_sync[GB + io_port_pkg::G_T1CAP_BIT];
  assign timer_one_io          = pin_sync[GB + io_port_pkg::G_T1IO_BIT];
  assign sync_serial_clock     = pin_sync[GB + io_port_pkg::G_SCK_BIT];
  assign serial_data_in        = pin_sync[GB + io_port_pkg::G_SI_BIT];
  assign wakeup_level          = pin_sync[LB +: PW];
  assign serial_receive_pin    = pin_sync[LB + io_port_pkg::L_RXD_BIT];
  assign serial_clock_pin      = pin_sync[LB + io_port_pkg::L_UCLK_BIT];

  // Read channel
  function automatic logic [PW-1:0] read_byte(input logic [7:0] a, output logic ok);
    logic [2:0] p;
    p  = a[6:4];
    ok = 1'b1;
    if (port_hit(a)) begin
      unique case (a[3:0])
        io_port_pkg::OFF_CFG:  return cfg_reg[p];
        io_port_pkg::OFF_DATA: return data_reg[p];
        default: begin
          if (p == 3'(io_port_pkg::PORT_F)) begin
            return pin_sync[FB +: PW] & io_port_pkg::F_MASK;
          end
          return pin_sync[32'(p) * PW +: PW];
        end
      endcase
    end
    if (a == io_port_pkg::ADDR_D_DATA) begin
      return d_port_reg;
    end
    if (a == io_port_pkg::ADDR_OPTION) begin
      return {{(PW-1){1'b0}}, wdog_en_reg};
    end
    ok = 1'b0;
    return '0;
  endfunction

  always_ff @(posedge aclk) begin
    logic [PW-1:0] rbyte;
    logic          rok;
    rbyte = '0;
    rok   = 1'b0;
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= io_port_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rbyte = read_byte(s_axi_araddr, rok);
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h00_0000, rbyte};
      s_axi_rresp   <= rok ? io_port_pkg::RESP_OKAY : io_port_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// File: verification/io_port_set_properties.sv
// Checker for the port set, bound to io_port_set.
// Assumes one clock domain and sees only the ports of io_port_set.
`timescale 1ns/1ns
module io_port_set_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [55:0] port_pin_in,
  input wire logic [55:0] port_pin_out,
  input wire logic [55:0] port_pin_oe,
  input wire logic [55:0] port_pin_pullup,
  input wire logic        oscillator_clock_in,
  input wire logic        halt_mode_req,
  input wire logic        idle_mode_req,
  input wire logic        serial_clock_phase_alt,
  input wire logic        halt_exit_clock_delay_en,
  input wire logic        watchdog_enable,
  input wire logic        external_interrupt_in,
  input wire logic [7:0]  wakeup_level
);
  localparam logic [7:0] G_CFG_ADDR  = 8'h50;
  localparam logic [7:0] G_DATA_ADDR = 8'h54;
  logic [7:0] aw_q;
  logic [7:0] w_q;
  logic       ws_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Address of the write in flight
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) begin
      aw_q <= s_axi_awaddr;
    end
  end

  // Data of the write in flight
  always_ff @(posedge aclk) begin
    if (s_axi_wvalid && s_axi_wready) begin
      w_q  <= s_axi_wdata[7:0];
      ws_q <= s_axi_wstrb[0];
    end
  end

  a_g6_input: assert property (
    !port_pin_oe[46] && !port_pin_pullup[46])
    else $error("G6 pin driven or pulled");
  a_g7_clock: assert property (
    $past(aresetn) && $past(aresetn, 2) |->
      port_pin_oe[47] && port_pin_out[47] == $past(oscillator_clock_in))
    else $error("G7 not copying clock");
  a_halt_pulse: assert property (
    $rose(s_axi_bvalid) && aw_q == G_DATA_ADDR && ws_q && w_q[7] |-> ##[0:1] halt_mode_req)
    else $error("halt request missing");
  a_idle_pulse: assert property (
    $rose(s_axi_bvalid) && aw_q == G_DATA_ADDR && ws_q && w_q[6] |-> ##[0:1] idle_mode_req)
    else $error("idle request missing");
  a_pulse_single: assert property (
    halt_mode_req || idle_mode_req |=> !halt_mode_req && !idle_mode_req)
    else $error("mode request longer than one cycle");
  a_g_config: assert property (
    $rose(s_axi_bvalid) && aw_q == G_CFG_ADDR && ws_q |=>
      serial_clock_phase_alt == w_q[6] && halt_exit_clock_delay_en == w_q[7])
    else $error("G config special bits wrong");
  a_wdog_pin: assert property (
    watchdog_enable && $past(watchdog_enable) && $past(watchdog_enable, 2) |->
      port_pin_pullup[41] && !port_pin_out[41])
    else $error("watchdog pin not open drain");
  a_pin_sync: assert property (
    $past(aresetn) && $past(aresetn, 2) |-> wakeup_level == $past(port_pin_in[55:48], 2)
      && external_interrupt_in == $past(port_pin_in[40], 2))
    else $error("alternate input level wrong");
endmodule

// File: verification/pin_board.sv
// Board model: resolves each pin from device drive, board drive and pull-up.
// Assumes device outputs change on aclk; floating pins wander every cycle.
`timescale 1ns/1ns
module pin_board (
  input  wire logic        aclk,
  input  wire logic [55:0] port_pin_out,
  input  wire logic [55:0] port_pin_oe,
  input  wire logic [55:0] port_pin_pullup,
  input  wire logic [55:0] board_drv,
  input  wire logic [55:0] board_en,
  output logic      [55:0] port_pin_in
);
  logic [55:0] float_reg = 56'h0;

  // Undriven pins change every cycle
  always @(posedge aclk) begin
    float_reg <= ~float_reg;
  end

  // Device drive wins, then board, then weak pull-up
  always_comb begin
    port_pin_in = (port_pin_oe & port_pin_out)
                | (~port_pin_oe & board_en & board_drv)
                | (~port_pin_oe & ~board_en & port_pin_pullup)
                | (~port_pin_oe & ~board_en & ~port_pin_pullup & float_reg);
  end
endmodule

// File: verification/tb_io_port_set.sv
// Testbench for io_port_set: AXI4-Lite master, board model, scenario tasks.
// Assumes the checker and board model are compiled before this file.
`timescale 1ns/1ns
module tb_io_port_set;
  localparam logic [1:0]  OKR = io_port_pkg::RESP_OKAY;
  localparam logic [1:0]  ERR = io_port_pkg::RESP_SLVERR;
  localparam logic [55:0] PAT = {8'h5a, 8'hc3, 8'h3b, 8'h96, 8'ha5, 8'h3c, 8'he1};
  logic        aclk = 1'b0, aresetn = 1'b0, oscillator_clock_in = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, watchdog_output_level = 1'b1;
  logic [55:0] board_drv = 56'h0, board_en = 56'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [55:0] port_pin_in, port_pin_out, port_pin_oe, port_pin_pullup;
  logic [7:0]  port_d_out, wakeup_level;
  logic        halt_mode_req, idle_mode_req, serial_clock_phase_alt, watchdog_enable;
  logic        halt_exit_clock_delay_en, external_interrupt_in, timer_one_capture_in;
  logic        timer_one_io, serial_data_in, sync_serial_clock;
  logic        serial_receive_pin, serial_clock_pin;
  int          n_errors, samples_checked, cycles, n_halt, n_idle;

  io_port_set io_port_set_inst (.*);
  pin_board pin_board_inst (.*);

  always #5 aclk = ~aclk;

  always @(posedge aclk) begin
    oscillator_clock_in <= ~oscillator_clock_in;
    cycles++;
    if (halt_mode_req === 1'b1) n_halt++;
    if (idle_mode_req === 1'b1) n_idle++;
    if (cycles > 4000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [55:0] g, input logic [55:0] e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(56'(s_axi_bresp), 56'(er));
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er, input logic [7:0] ed,
                    input logic [7:0] m);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(56'(s_axi_rresp), 56'(er));
    chk(56'(s_axi_rdata & {24'h0, m}), 56'(ed));
    @(posedge aclk);
  endtask

  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    chk(56'(port_d_out), 56'hff);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask

  task automatic t_pins();
    board_drv <= PAT;
    board_en <= {56{1'b1}};
    repeat (4) @(posedge aclk);
    for (int p = 0; p < 7; p++) begin
      rd(8'(p * 16 + 8), OKR,
         PAT[p*8 +: 8] & (p == 4 ? 8'h0f : 8'hff) & (p == 5 ? 8'h7f : 8'hff),
         p == 5 ? 8'h7f : 8'hff);
    end
    chk(56'({external_interrupt_in, timer_one_capture_in, timer_one_io, sync_serial_clock,
             serial_data_in, serial_receive_pin, serial_clock_pin, wakeup_level}),
        56'({7'b1000111, 8'h5a}));
    board_en <= 56'h0;
  endtask

  task automatic t_modes();
    for (int p = 0; p < 7; p++) begin
      if (p != 5) begin
        wr(8'(p * 16), 8'h0c, OKR);
        wr(8'(p * 16 + 4), 8'h0a, OKR);
        repeat (2) @(posedge aclk);
        chk(56'({port_pin_oe[p*8 +: 4], port_pin_pullup[p*8 +: 4], port_pin_out[p*8+2 +: 2]}),
            56'(10'b1100_0010_10));
        rd(8'(p * 16), OKR, 8'h0c, 8'hff);
        rd(8'(p * 16 + 4), OKR, 8'h0a, 8'hff);
      end
    end
    wr(8'h40, 8'hff, OKR);
    repeat (2) @(posedge aclk);
    chk(56'(port_pin_oe[39:36]), 56'h0);
    rd(8'h40, OKR, 8'h0f, 8'hff);
    wr(8'h08, 8'hff, OKR);
    wr(8'h78, 8'h01, ERR);
    rd(8'h7c, ERR, 8'h00, 8'hff);
  endtask

  task automatic t_port_g();
    int h0;
    int i0;
    wr(8'h50, 8'hc0, OKR);
    repeat (2) @(posedge aclk);
    chk(56'({serial_clock_phase_alt, halt_exit_clock_delay_en}), 56'h3);
    rd(8'h50, OKR, 8'hc0, 8'hff);
    h0 = n_halt;
    i0 = n_idle;
    wr(8'h54, 8'hff, OKR);
    repeat (3) @(posedge aclk);
    chk(56'(n_halt - h0), 56'h1);
    chk(56'(n_idle - i0), 56'h1);
    rd(8'h54, OKR, 8'h3f, 8'hff);
    chk(56'({port_pin_oe[47:46], port_pin_pullup[46]}), 56'h4);
    wr(8'h54, 8'h40, OKR);
    repeat (3) @(posedge aclk);
    chk(56'(n_halt - h0), 56'h1);
    chk(56'(n_idle - i0), 56'h2);
    wr(8'h50, 8'h00, OKR);
    repeat (2) @(posedge aclk);
    chk(56'({serial_clock_phase_alt, halt_exit_clock_delay_en}), 56'h0);
  endtask

  task automatic t_wdog();
    wr(8'h50, 8'h02, OKR);
    wr(8'h54, 8'h02, OKR);
    watchdog_output_level <= 1'b0;
    wr(8'h74, 8'h01, OKR);
    repeat (4) @(posedge aclk);
    chk(56'({watchdog_enable, port_pin_oe[41], port_pin_out[41], port_pin_pullup[41]}),
        56'hd);
    watchdog_output_level <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(56'({port_pin_oe[41], port_pin_pullup[41]}), 56'h1);
    wr(8'h74, 8'h00, OKR);
    repeat (4) @(posedge aclk);
    chk(56'({watchdog_enable, port_pin_oe[41], port_pin_out[41], port_pin_pullup[41]}),
        56'h6);
  endtask

  task automatic t_port_d();
    wr(8'h70, 8'h00, OKR);
    repeat (2) @(posedge aclk);
    chk(56'(port_d_out), 56'h0);
    do_reset();
    rd(8'h70, OKR, 8'hff, 8'hff);
    rd(8'h50, OKR, 8'h00, 8'hff);
  endtask

  initial begin
    do_reset();
    t_pins();
    t_modes();
    t_port_g();
    t_wdog();
    t_port_d();
    end_sim();
  end
endmodule

bind io_port_set io_port_set_checker io_port_set_checker_inst (.*);
